// ### hdl/nsr_pkg.sv
// types shared by the flash status block
package nsr_pkg;

    // power reduction state, one-hot
    typedef enum logic [1:0] {
        NSR_ACTIVE  = 2'b01,
        NSR_REDUCED = 2'b10
    } nsr_power_e;

    // sleep power reduction setting code
    typedef logic [1:0]  nsr_sleep_t;

    // halfword address to the array
    typedef logic [21:0] nsr_address_t;

endpackage

// ### hdl/nsr_power.sv
// power reduction state of the flash array
`timescale 1ns/1ps
`include "nsr_regs.svh"

module nsr_power (
    input  wire logic              ref_clk_in,   // block clock
    input  wire logic              reset_in,     // synchronous reset, high
    input  wire logic              enter_cmd_in, // enter command pulse
    input  wire logic              exit_cmd_in,  // exit command pulse
    input  wire logic              sleep_in_in,  // sleep entry pulse
    input  wire logic              sleep_out_in, // sleep exit pulse
    input  wire logic              access_in,    // bus access to the array
    input  nsr_pkg::nsr_sleep_t    setting_in,   // sleep setting
    output logic                   reduced_out   // in power reduction
);

    nsr_pkg::nsr_power_e state_q;   // current state
    nsr_pkg::nsr_power_e state_d;   // next state
    logic                auto_ok;   // sleep entry may reduce power

    // reserved code behaves like disabled
    assign auto_ok = (setting_in == `NSR_SLEEP_WAKE_ON_ACCESS) ||
                     (setting_in == `NSR_SLEEP_WAKE_ON_EXIT);

    // next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            nsr_pkg::NSR_ACTIVE: begin
                // command, or sleep with auto reduction allowed
                if (enter_cmd_in || (sleep_in_in && auto_ok)) begin
                    state_d = nsr_pkg::NSR_REDUCED;
                end
            end
            nsr_pkg::NSR_REDUCED: begin
                // access, exit command, or sleep exit when set so
                if (access_in || exit_cmd_in ||
                    (sleep_out_in && setting_in == `NSR_SLEEP_WAKE_ON_EXIT)) begin
                    state_d = nsr_pkg::NSR_ACTIVE;
                end
            end
            default: begin
                state_d = nsr_pkg::NSR_ACTIVE;
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            state_q <= nsr_pkg::NSR_ACTIVE;
        end else begin
            state_q <= state_d;
        end
    end

    // registered indication
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            reduced_out <= 1'b0;
        end else begin
            reduced_out <= (state_d == nsr_pkg::NSR_REDUCED);
        end
    end

endmodule

// ### hdl/nsr_regs.svh
// register offsets, field positions, reset values and setting codes of the flash status block
`ifndef NSR_REGS_SVH
`define NSR_REGS_SVH

// byte offsets on the register port
`define NSR_OFS_IRQ_ENABLE_CLEAR 8'h0c
`define NSR_OFS_IRQ_ENABLE_SET   8'h10
`define NSR_OFS_IRQ_FLAGS        8'h14
`define NSR_OFS_STATUS           8'h18
`define NSR_OFS_COMMAND_ADDRESS  8'h1c
`define NSR_OFS_REGION_LOCK      8'h20

// interrupt enable and flag layout
`define NSR_IRQ_READY_BIT 0
`define NSR_IRQ_ERROR_BIT 1
`define NSR_IRQ_MSB       1

// controller status layout
`define NSR_ST_POWER_REDUCED_BIT 0
`define NSR_ST_LOAD_BIT          1
`define NSR_ST_BAD_COMMAND_BIT   2
`define NSR_ST_LOCK_VIOL_BIT     3
`define NSR_ST_ARRAY_ERROR_BIT   4
`define NSR_ST_SECURITY_BIT      8
`define NSR_ST_STICKY_LSB        1
`define NSR_ST_STICKY_MSB        4

// field widths
`define NSR_ADDRESS_MSB 21
`define NSR_LOCK_MSB    15

// reset values
`define NSR_IRQ_ENABLE_RST 2'h0
`define NSR_STICKY_RST     1'h0
`define NSR_ADDRESS_RST    22'h000000
`define NSR_LOCK_RST       16'h0000
`define NSR_RDATA_RST      32'h00000000

// sleep power reduction setting codes
`define NSR_SLEEP_WAKE_ON_ACCESS 2'h0
`define NSR_SLEEP_WAKE_ON_EXIT   2'h1
`define NSR_SLEEP_DISABLED       2'h3

`endif

// ### hdl/nsr_sticky.sv
// bank of sticky flags, hardware set wins over write-one clear
`timescale 1ns/1ps
`include "nsr_regs.svh"

module nsr_sticky #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk_in,  // block clock
    input  wire logic             reset_in,    // synchronous reset, high
    input  wire logic [WIDTH-1:0] set_in,      // event pulses
    input  wire logic [WIDTH-1:0] clear_in,    // clear pulses
    output logic      [WIDTH-1:0] flag_out     // sticky flags
);

    // one flop per flag
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
            always_ff @(posedge ref_clk_in) begin
                if (reset_in) begin
                    flag_out[i] <= `NSR_STICKY_RST;
                end else if (set_in[i]) begin
                    // event in the clear cycle is kept
                    flag_out[i] <= 1'b1;
                end else if (clear_in[i]) begin
                    flag_out[i] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule

// ### hdl/nsr_top.sv
// status, interrupt, address and region lock registers of the flash controller
//
// Operation
// - one written to enable-clear drops that enable
// - one written to enable-set raises that enable
// - both enable registers show one shared set
// - error flag sticks on any error, write-one clears
// - ready flag reads zero while busy
// - reserved bits read zero, software writes zero
// - status bit 8 shows security state, read-only
// - status bit 4 latches array error
// - status bit 3 latches lock violation
// - status bit 2 latches bad command or key
// - status bit 1 marks page buffer loaded
// - power reduced bit follows commands, sleep, access
// - 22-bit halfword address drives the array
// - address follows page loads and software writes
// - region lock bits read-only, zero means locked
// - sleep setting picks automatic power reduction behaviour
`timescale 1ns/1ps
`include "nsr_regs.svh"

module nsr_top (
    input  wire logic        ref_clk_in,                       // 10 mhz block clock
    input  wire logic        reset_in,                         // synchronous reset, high
    // register port
    input  wire logic [7:0]  bus_address_in,                   // byte address
    input  wire logic [31:0] bus_wdata_in,                     // write data
    input  wire logic        bus_write_in,                     // write strobe
    input  wire logic        bus_read_in,                      // read strobe
    output logic      [31:0] bus_rdata_out,                    // read data, next cycle
    // controller events and state
    input  wire logic        busy_in,                          // programming or erasing
    input  wire logic        array_error_in,                   // array error pulse
    input  wire logic        lock_violation_error_in,          // locked region program pulse
    input  wire logic        bad_command_error_in,             // bad command or key pulse
    input  wire logic        page_load_in,                     // word loaded into page buffer
    input  wire logic [21:0] page_load_address_in,             // halfword target of the load
    input  wire logic        page_write_in,                    // page write command pulse
    input  wire logic        page_buffer_clear_cmd_in,         // page buffer clear pulse
    input  wire logic        command_execute_in,               // command execute pulse
    input  wire logic        security_active_in,               // security protection level
    // region lock update from the command logic
    input  wire logic        lock_update_in,                   // lock bits update pulse
    input  wire logic [15:0] lock_value_in,                    // new lock bits
    // power reduction control
    input  wire logic        enter_power_reduction_cmd_in,     // enter command pulse
    input  wire logic        exit_power_reduction_cmd_in,      // exit command pulse
    input  wire logic        sleep_enter_in,                   // sleep entry pulse
    input  wire logic        sleep_exit_in,                    // sleep exit pulse
    input  wire logic        array_access_in,                  // bus access to array pulse
    input  wire logic [1:0]  sleep_power_reduction_setting_in, // sleep setting code
    // outputs to the rest of the controller
    output logic [21:0]      command_address_out,              // live address register
    output logic [21:0]      exec_address_out,                 // address of last execute
    output logic [15:0]      region_lock_out,                  // lock bits, zero locked
    output logic             power_reduced_state_out,          // array in power reduction
    output logic             irq_out                           // interrupt request, level
);

    // decoded accesses
    logic                     wr_enable_clear;  // write to enable-clear
    logic                     wr_enable_set;    // write to enable-set
    logic                     wr_flags;         // write to flag register
    logic                     wr_status;        // write to status
    logic                     wr_address;       // write to address

    // interrupt state
    logic [`NSR_IRQ_MSB:0]    irq_enable_q;     // shared enable bits
    logic [`NSR_IRQ_MSB:0]    irq_enable_d;     // next enable bits
    logic [`NSR_IRQ_MSB:0]    irq_flags;        // current flag view
    logic                     error_flag;       // sticky error flag
    logic                     error_event;      // any error this cycle
    logic                     error_clear;      // write-one to error flag
    logic                     ready_q;          // registered ready level

    // status state
    logic [3:0]               status_set;       // events for status bits 4:1
    logic [3:0]               status_clear;     // clears for status bits 4:1
    logic [3:0]               status_flags;     // sticky status bits 4:1
    logic                     security_q;       // registered security level
    logic                     power_reduced;    // from power state machine

    // address and lock state
    nsr_pkg::nsr_address_t    address_q;        // command address register
    nsr_pkg::nsr_address_t    exec_address_q;   // latched at execute
    logic [`NSR_LOCK_MSB:0]   lock_q;           // region lock bits

    // read path
    logic [31:0]              rdata_d;          // read word before the flop
    logic [31:0]              rdata_q;          // read word register
    logic                     irq_q;            // interrupt register

    // write decode, one register per offset
    always_comb begin
        wr_enable_clear = bus_write_in && (bus_address_in == `NSR_OFS_IRQ_ENABLE_CLEAR);
        wr_enable_set   = bus_write_in && (bus_address_in == `NSR_OFS_IRQ_ENABLE_SET);
        wr_flags        = bus_write_in && (bus_address_in == `NSR_OFS_IRQ_FLAGS);
        wr_status       = bus_write_in && (bus_address_in == `NSR_OFS_STATUS);
        wr_address      = bus_write_in && (bus_address_in == `NSR_OFS_COMMAND_ADDRESS);
    end

    // enable bits: set and clear registers act on one copy
    always_comb begin
        irq_enable_d = irq_enable_q;
        if (wr_enable_set) begin
            // ones set, zeros leave alone
            irq_enable_d = irq_enable_q | bus_wdata_in[`NSR_IRQ_MSB:0];
        end else if (wr_enable_clear) begin
            // ones clear, zeros leave alone
            irq_enable_d = irq_enable_q & ~bus_wdata_in[`NSR_IRQ_MSB:0];
        end
    end

    // enable register
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            irq_enable_q <= `NSR_IRQ_ENABLE_RST;
        end else begin
            irq_enable_q <= irq_enable_d;
        end
    end

    // error flag sources and write-one clear
    always_comb begin
        error_event = array_error_in || lock_violation_error_in || bad_command_error_in;
        error_clear = wr_flags && bus_wdata_in[`NSR_IRQ_ERROR_BIT];
    end

    // sticky error interrupt flag
    nsr_sticky #(
        .WIDTH (1)
    ) u_error_flag (
        .ref_clk_in (ref_clk_in),
        .reset_in   (reset_in),
        .set_in     (error_event),
        .clear_in   (error_clear),
        .flag_out   (error_flag)
    );

    // ready follows the busy level, no latching
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= ~busy_in;
        end
    end

    // flag view shared by read path and interrupt
    always_comb begin
        irq_flags                     = '0;
        irq_flags[`NSR_IRQ_READY_BIT] = ready_q;
        irq_flags[`NSR_IRQ_ERROR_BIT] = error_flag;
    end

    // status events, one per sticky bit
    always_comb begin
        status_set   = '0;
        status_clear = '0;
        // array error
        status_set[`NSR_ST_ARRAY_ERROR_BIT - `NSR_ST_STICKY_LSB] = array_error_in;
        // lock violation
        status_set[`NSR_ST_LOCK_VIOL_BIT - `NSR_ST_STICKY_LSB]   = lock_violation_error_in;
        // bad command or key
        status_set[`NSR_ST_BAD_COMMAND_BIT - `NSR_ST_STICKY_LSB] = bad_command_error_in;
        // page buffer loaded
        status_set[`NSR_ST_LOAD_BIT - `NSR_ST_STICKY_LSB]        = page_load_in;
        // write-one clears any of bits 4:1
        if (wr_status) begin
            status_clear = bus_wdata_in[`NSR_ST_STICKY_MSB:`NSR_ST_STICKY_LSB];
        end
        // page write or buffer clear also drops the load mark
        if (page_write_in || page_buffer_clear_cmd_in) begin
            status_clear[`NSR_ST_LOAD_BIT - `NSR_ST_STICKY_LSB] = 1'b1;
        end
    end

    // sticky status bits 4:1
    nsr_sticky #(
        .WIDTH (4)
    ) u_status_flags (
        .ref_clk_in (ref_clk_in),
        .reset_in   (reset_in),
        .set_in     (status_set),
        .clear_in   (status_clear),
        .flag_out   (status_flags)
    );

    // security level, read-only mirror
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            security_q <= 1'b0;
        end else begin
            security_q <= security_active_in;
        end
    end

    // power reduction state machine
    nsr_power u_power (
        .ref_clk_in   (ref_clk_in),
        .reset_in     (reset_in),
        .enter_cmd_in (enter_power_reduction_cmd_in),
        .exit_cmd_in  (exit_power_reduction_cmd_in),
        .sleep_in_in  (sleep_enter_in),
        .sleep_out_in (sleep_exit_in),
        .access_in    (array_access_in),
        .setting_in   (sleep_power_reduction_setting_in),
        .reduced_out  (power_reduced)
    );

    // address register, page loads win over software writes
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            address_q <= `NSR_ADDRESS_RST;
        end else if (page_load_in) begin
            // follows each page buffer write
            address_q <= page_load_address_in;
        end else if (wr_address) begin
            // software supplies halfword offset, upper bits dropped
            address_q <= bus_wdata_in[`NSR_ADDRESS_MSB:0];
        end
    end

    // address handed to the array when a command runs
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            exec_address_q <= `NSR_ADDRESS_RST;
        end else if (command_execute_in) begin
            exec_address_q <= address_q;
        end
    end

    // lock bits change only through the command logic
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            lock_q <= `NSR_LOCK_RST;
        end else if (lock_update_in) begin
            lock_q <= lock_value_in;
        end
    end

    // read multiplexer, unmapped and reserved read zero
    always_comb begin
        rdata_d = `NSR_RDATA_RST;
        if (bus_read_in) begin
            unique case (bus_address_in)
                // both enable offsets show the same bits
                `NSR_OFS_IRQ_ENABLE_CLEAR: begin
                    rdata_d[`NSR_IRQ_MSB:0] = irq_enable_q;
                end
                `NSR_OFS_IRQ_ENABLE_SET: begin
                    rdata_d[`NSR_IRQ_MSB:0] = irq_enable_q;
                end
                // flag register, bits 31:2 zero
                `NSR_OFS_IRQ_FLAGS: begin
                    rdata_d[`NSR_IRQ_MSB:0] = irq_flags;
                end
                // status, reserved bits stay zero
                `NSR_OFS_STATUS: begin
                    rdata_d[`NSR_ST_POWER_REDUCED_BIT] = power_reduced;
                    rdata_d[`NSR_ST_STICKY_MSB:`NSR_ST_STICKY_LSB] = status_flags;
                    rdata_d[`NSR_ST_SECURITY_BIT] = security_q;
                end
                // address, bits 31:22 zero
                `NSR_OFS_COMMAND_ADDRESS: begin
                    rdata_d[`NSR_ADDRESS_MSB:0] = address_q;
                end
                // lock bits, read-only
                `NSR_OFS_REGION_LOCK: begin
                    rdata_d[`NSR_LOCK_MSB:0] = lock_q;
                end
                default: begin
                    rdata_d = `NSR_RDATA_RST;
                end
            endcase
        end
    end

    // read data register, valid the cycle after the strobe
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            rdata_q <= `NSR_RDATA_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // interrupt request from flags gated by enables
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_flags & irq_enable_q);
        end
    end

    // outputs straight from flops
    assign bus_rdata_out           = rdata_q;
    assign irq_out                 = irq_q;
    assign command_address_out     = address_q;
    assign exec_address_out        = exec_address_q;
    assign region_lock_out         = lock_q;
    assign power_reduced_state_out = power_reduced;

endmodule

// ### tb/nsr_top_monitor.sv
// concurrent checks on the ports of the flash status block
`timescale 1ns/1ps

module nsr_top_monitor (
    // every port mirrors the block port of the same name
    input wire logic        ref_clk_in,
    input wire logic        reset_in,
    input wire logic [7:0]  bus_address_in,
    input wire logic        bus_write_in,
    input wire logic        bus_read_in,
    input wire logic [31:0] bus_rdata_out,
    input wire logic        page_load_in,
    input wire logic [21:0] page_load_address_in,
    input wire logic        command_execute_in,
    input wire logic        lock_update_in,
    input wire logic [15:0] lock_value_in,
    input wire logic        enter_power_reduction_cmd_in,
    input wire logic        exit_power_reduction_cmd_in,
    input wire logic        sleep_enter_in,
    input wire logic        sleep_exit_in,
    input wire logic        array_access_in,
    input wire logic [1:0]  sleep_power_reduction_setting_in,
    input wire logic [21:0] command_address_out,
    input wire logic [21:0] exec_address_out,
    input wire logic [15:0] region_lock_out,
    input wire logic        power_reduced_state_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    // read strobes of the lock and address places
    sequence lock_rd;
        bus_read_in && bus_address_in == 8'h20 && !lock_update_in;
    endsequence
    sequence addr_rd;
        bus_read_in && bus_address_in == 8'h1c && !page_load_in;
    endsequence

    AST_RDATA_IDLE: assert property (!bus_read_in |=> bus_rdata_out == 32'h00000000)
        else $error("read data not zero outside a read");
    AST_LOCK_READ: assert property (lock_rd |=> bus_rdata_out == {16'h0000, region_lock_out})
        else $error("lock read differs from lock bits");
    AST_ADDR_READ: assert property (addr_rd |=> bus_rdata_out == {10'h000, command_address_out})
        else $error("address read differs from register");
    AST_LOCK_LOAD: assert property (lock_update_in |=> region_lock_out == $past(lock_value_in))
        else $error("lock bits not loaded");
    AST_LOCK_HOLD: assert property (!lock_update_in |=> $stable(region_lock_out))
        else $error("lock bits moved without update");
    AST_ADDR_LOAD: assert property (page_load_in |=> command_address_out == $past(page_load_address_in))
        else $error("address not taken from page load");
    AST_EXEC_ADDR: assert property (command_execute_in && !page_load_in && !bus_write_in
        |=> exec_address_out == $past(command_address_out))
        else $error("executed address wrong");
    AST_PWR_ON: assert property (enter_power_reduction_cmd_in && !exit_power_reduction_cmd_in
        && !array_access_in && !sleep_exit_in |=> power_reduced_state_out)
        else $error("enter command did not reduce power");
    AST_PWR_OFF: assert property (exit_power_reduction_cmd_in && !enter_power_reduction_cmd_in
        && !sleep_enter_in |=> !power_reduced_state_out)
        else $error("exit command did not restore power");
    AST_SLEEP_OFF: assert property (sleep_enter_in && sleep_power_reduction_setting_in == 2'h3
        && !enter_power_reduction_cmd_in && !power_reduced_state_out
        |=> !power_reduced_state_out)
        else $error("sleep reduced power while disabled");
endmodule

bind nsr_top nsr_top_monitor nsr_top_monitor_inst (.ref_clk_in, .reset_in, .bus_address_in,
    .bus_write_in, .bus_read_in, .bus_rdata_out, .page_load_in, .page_load_address_in,
    .command_execute_in, .lock_update_in, .lock_value_in, .enter_power_reduction_cmd_in,
    .exit_power_reduction_cmd_in, .sleep_enter_in, .sleep_exit_in, .array_access_in,
    .sleep_power_reduction_setting_in, .command_address_out, .exec_address_out,
    .region_lock_out, .power_reduced_state_out);

// ### tb/tb_top.sv
// self-checking bench for the flash status block
`timescale 1ns/1ps

module tb_top;
    // bus, level and event drives, and the block's outputs
    logic        ref_clk_in;
    logic        reset_in;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        busy;
    logic        sec;
    logic [21:0] ld_addr;
    logic [21:0] cmd_addr;
    logic [21:0] exec_addr;
    logic [15:0] lock_val;
    logic [15:0] lock_bits;
    logic [1:0]  setting;
    logic [12:0] ev;
    logic        pwr;
    logic        irq;
    integer      err_count, tests_run, seed, i, r;
    integer      en, flg, st, pm, lk, am;  // bench model state

    nsr_top nsr_top_inst (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
        .bus_address_in(addr), .bus_wdata_in(wdata), .bus_write_in(wr), .bus_read_in(rd),
        .bus_rdata_out(rdata), .busy_in(busy), .array_error_in(ev[0]),
        .lock_violation_error_in(ev[1]), .bad_command_error_in(ev[2]), .page_load_in(ev[3]),
        .page_load_address_in(ld_addr), .page_write_in(ev[4]),
        .page_buffer_clear_cmd_in(ev[5]), .command_execute_in(ev[6]),
        .security_active_in(sec), .lock_update_in(ev[7]), .lock_value_in(lock_val),
        .enter_power_reduction_cmd_in(ev[8]), .exit_power_reduction_cmd_in(ev[9]),
        .sleep_enter_in(ev[10]), .sleep_exit_in(ev[11]), .array_access_in(ev[12]),
        .sleep_power_reduction_setting_in(setting), .command_address_out(cmd_addr),
        .exec_address_out(exec_addr), .region_lock_out(lock_bits),
        .power_reduced_state_out(pwr), .irq_out(irq));

    // free running clock
    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask

    // one-cycle write
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk_in);
        wr <= 1'b0;
    endtask

    // one-cycle read, data checked in the following cycle
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk_in);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask

    // one-cycle event pulse
    task automatic pulse(input int k);
        @(posedge ref_clk_in);
        ev[k] <= 1'b1;
        @(posedge ref_clk_in);
        ev <= 13'h0000;
        #1;
    endtask

    // expected status word
    function automatic logic [31:0] stx();
        return st | pm | (sec ? 256 : 0);
    endfunction

    // expected interrupt level
    function automatic logic exp_irq();
        return ((en & 1) != 0 && !busy) || ((en & 2) != 0 && flg != 0);
    endfunction

    // verdict and end of run
    task automatic wrap_up;
        if (err_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        err_count = err_count + 1;
        wrap_up;
    end

    // main sequence
    initial begin
        seed = 83; err_count = 0; tests_run = 0;
        en = 0; flg = 0; st = 0; pm = 0; lk = 0; am = 0;
        reset_in = 1'b1; addr = 8'h00; wdata = 32'h0; wr = 1'b0; rd = 1'b0; busy = 1'b0;
        sec = 1'b0; ld_addr = 22'h0; lock_val = 16'h0; setting = 2'h3; ev = 13'h0000;
        repeat (16) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        // reset values and an unmapped place
        rd_reg(8'h0c, 32'h0); rd_reg(8'h10, 32'h0); rd_reg(8'h14, 32'h1);
        rd_reg(8'h18, 32'h0); rd_reg(8'h1c, 32'h0); rd_reg(8'h04, 32'h0);
        // enables through set and clear places
        for (i = 0; i < 8; i++) begin
            r = $random(seed);
            wr_reg(8'h10, r & 3); en = en | (r & 3);
            rd_reg(8'h0c, en);
            r = $random(seed);
            wr_reg(8'h0c, r & 3); en = en & ~r & 3;
            rd_reg(8'h10, en);
        end
        // each error source
        for (i = 0; i < 3; i++) begin
            wr_reg(8'h10, 32'h2); en = en | 2;
            pulse(i); flg = 1; st = st | (16 >> i);
            rd_reg(8'h18, stx());
            chk(irq, exp_irq());
            rd_reg(8'h14, 3);
            wr_reg(8'h14, 32'h2); flg = 0;
            rd_reg(8'h14, 1);
            wr_reg(8'h18, 16 >> i); st = 0;
            rd_reg(8'h18, stx());
        end
        // ready follows busy
        wr_reg(8'h10, 32'h1); en = 3;
        @(posedge ref_clk_in) busy <= 1'b1;
        rd_reg(8'h14, 0);
        chk(irq, exp_irq());
        @(posedge ref_clk_in) busy <= 1'b0;
        rd_reg(8'h14, 1);
        chk(irq, exp_irq());
        wr_reg(8'h0c, 32'h3); en = 0;
        rd_reg(8'h10, 0);
        chk(irq, exp_irq());
        // page loads and the three ways to end them
        for (i = 0; i < 3; i++) begin
            r = $random(seed);
            @(posedge ref_clk_in) ld_addr <= r[21:0];
            am = r & 32'h3fffff;
            pulse(3); st = 2;
            rd_reg(8'h1c, am);
            rd_reg(8'h18, stx());
            if (i == 0) pulse(4); else if (i == 1) pulse(5); else wr_reg(8'h18, 32'h2);
            st = 0;
            rd_reg(8'h18, stx());
        end
        // software address and execute
        r = $random(seed);
        wr_reg(8'h1c, r & 32'h3fffff); am = r & 32'h3fffff;
        rd_reg(8'h1c, am);
        pulse(6);
        chk(exec_addr, am);
        // lock bits load, write ignored
        r = $random(seed);
        @(posedge ref_clk_in) lock_val <= r[15:0];
        pulse(7); lk = r & 32'hffff;
        rd_reg(8'h20, lk);
        wr_reg(8'h20, ~lk & 32'hffff);
        rd_reg(8'h20, lk);
        // sleep settings then commands
        for (i = 0; i < 3; i++) begin
            @(posedge ref_clk_in) setting <= (i == 2) ? 2'h3 : 2'(i);
            pulse(10); pm = (i != 2);
            rd_reg(8'h18, stx());
            pulse(11); if (i == 1) pm = 0;
            chk(pwr, pm);
            pulse(12); pm = 0;
            chk(pwr, pm);
        end
        pulse(8); pm = 1;
        rd_reg(8'h18, stx());
        pulse(9); pm = 0;
        chk(pwr, pm);
        // security level, read-only bits ignore writes
        @(posedge ref_clk_in) sec <= 1'b1;
        wr_reg(8'h18, 32'h101);
        rd_reg(8'h18, stx());
        wrap_up;
    end
endmodule
